// ---- design/bridge_config_header_08_1c.sv ----
// Bridge configuration header registers at offsets 08h to 1Ch with I/O window decode.
//
// What this block does
// - Revision byte at 08h is fixed, read-only.
// - Programming interface byte reads as zero.
// - Sub-class byte reads 04h, bus-to-bus bridge.
// - Base class byte reads 06h, bridge.
// - Cache line size writable, resets zero, inert.
// - Both latency timers read zero always.
// - Header type byte reads 01h.
// - Upstream bus number writable, resets zero.
// - Downstream bus number writable, resets zero.
// - Highest bus number writable, resets zero.
// - I/O capability nibbles read 1, 32-bit.
// - Limit nibble gives window top bits 15:12.
// - Inclusive window range decides I/O forwarding.
// - Window bits 31:16 come from upper registers.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bridge_config_header_08_1c
    import bridge_cfg_pkg::*;
#(
    // Arbitrary neutral revision value.
    parameter logic [7:0] REVISION_CODE = 8'hA1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [bridge_cfg_pkg::ADDR_W-1:0] addr,
    input wire logic [bridge_cfg_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [bridge_cfg_pkg::DATA_W-1:0] rdata,
    output logic [7:0] upstream_bus_number,
    output logic [7:0] downstream_bus_number,
    output logic [7:0] highest_bus_number,
    input wire logic [15:0] io_base_upper,
    input wire logic [15:0] io_limit_upper,
    input wire logic io_valid,
    input wire logic [31:0] io_addr,
    output logic io_decided,
    output logic io_forward
);
    import bridge_cfg_pkg::*;

    logic [7:0] cache_line_size_reg;
    logic [7:0] cache_line_size_next;
    logic [7:0] upstream_bus_reg;
    logic [7:0] upstream_bus_next;
    logic [7:0] downstream_bus_reg;
    logic [7:0] downstream_bus_next;
    logic [7:0] highest_bus_reg;
    logic [7:0] highest_bus_next;
    logic [3:0] io_base_nib_reg;
    logic [3:0] io_base_nib_next;
    logic [3:0] io_limit_nib_reg;
    logic [3:0] io_limit_nib_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wr_header;
    logic wr_bus;
    logic wr_io;

    // Word-aligned decode; any other address is unmapped.
    assign wr_header = wr && (addr == OFS_HEADER);
    assign wr_bus = wr && (addr == OFS_BUS);
    assign wr_io = wr && (addr == OFS_IO);

    // Only the writable bytes take write data; hardwired bytes have no storage.
    always_comb
    begin
        cache_line_size_next = cache_line_size_reg;
        if (wr_header)
        begin
            cache_line_size_next = wdata[CLSZ_LSB +: 8];
        end
    end

    always_comb
    begin
        upstream_bus_next = upstream_bus_reg;
        downstream_bus_next = downstream_bus_reg;
        highest_bus_next = highest_bus_reg;
        if (wr_bus)
        begin
            upstream_bus_next = wdata[UP_BUS_LSB +: 8];
            downstream_bus_next = wdata[DOWN_BUS_LSB +: 8];
            highest_bus_next = wdata[HIGH_BUS_LSB +: 8];
        end
    end

    always_comb
    begin
        io_base_nib_next = io_base_nib_reg;
        io_limit_nib_next = io_limit_nib_reg;
        if (wr_io)
        begin
            io_base_nib_next = wdata[IO_BASE_LSB +: 4];
            io_limit_nib_next = wdata[IO_LIMIT_LSB +: 4];
        end
    end

    // Cache line size is storage only; nothing but the read data assembly reads it.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cache_line_size_reg <= CLSZ_RST;
        end
        else
        begin
            cache_line_size_reg <= cache_line_size_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upstream_bus_reg <= BUS_RST;
            downstream_bus_reg <= BUS_RST;
            highest_bus_reg <= BUS_RST;
        end
        else
        begin
            upstream_bus_reg <= upstream_bus_next;
            downstream_bus_reg <= downstream_bus_next;
            highest_bus_reg <= highest_bus_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_base_nib_reg <= IO_NIB_RST;
            io_limit_nib_reg <= IO_NIB_RST;
        end
        else
        begin
            io_base_nib_reg <= io_base_nib_next;
            io_limit_nib_reg <= io_limit_nib_next;
        end
    end

    // Read data assembly; unmapped offsets and idle cycles return zero.
    always_comb
    begin
        rdata_next = ZERO_WORD;
        if (rd)
        begin
            case (addr)
                OFS_CLASS:
                begin
                    rdata_next[REV_LSB +: 8] = REVISION_CODE;
                    rdata_next[PROG_IF_LSB +: 8] = PROG_IF_VAL;
                    rdata_next[SUBCLASS_LSB +: 8] = SUBCLASS_VAL;
                    rdata_next[BASECLASS_LSB +: 8] = BASECLASS_VAL;
                end
                OFS_HEADER:
                begin
                    rdata_next[CLSZ_LSB +: 8] = cache_line_size_reg;
                    rdata_next[PRI_LAT_LSB +: 8] = LATENCY_VAL;
                    rdata_next[HDR_TYPE_LSB +: 8] = HDR_TYPE_VAL;
                end
                OFS_BUS:
                begin
                    rdata_next[UP_BUS_LSB +: 8] = upstream_bus_reg;
                    rdata_next[DOWN_BUS_LSB +: 8] = downstream_bus_reg;
                    rdata_next[HIGH_BUS_LSB +: 8] = highest_bus_reg;
                    rdata_next[SEC_LAT_LSB +: 8] = LATENCY_VAL;
                end
                OFS_IO:
                begin
                    rdata_next[IO_BASE_CAP_LSB +: 4] = IO_CAP_VAL;
                    rdata_next[IO_BASE_LSB +: 4] = io_base_nib_reg;
                    rdata_next[IO_LIMIT_CAP_LSB +: 4] = IO_CAP_VAL;
                    rdata_next[IO_LIMIT_LSB +: 4] = io_limit_nib_reg;
                end
                default:
                begin
                    rdata_next = ZERO_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= ZERO_WORD;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign upstream_bus_number = upstream_bus_reg;
    assign downstream_bus_number = downstream_bus_reg;
    assign highest_bus_number = highest_bus_reg;

    io_window_check u_io_window_check (
        .clk(clk),
        .rst_n(rst_n),
        .base_nib(io_base_nib_reg),
        .limit_nib(io_limit_nib_reg),
        .base_upper(io_base_upper),
        .limit_upper(io_limit_upper),
        .io_valid(io_valid),
        .io_addr(io_addr),
        .io_decided(io_decided),
        .io_forward(io_forward)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Identification and header words: every byte but the cache line size is hardwired.
    chk_revision_byte: assert property (rd && addr == 8'h08 |=> rdata[7:0] == REVISION_CODE)
        else $error("Revision byte read wrong");
    chk_prog_if_zero: assert property (rd && addr == 8'h08 |=> rdata[15:8] == 8'h00)
        else $error("Programming interface byte not zero");
    chk_subclass_byte: assert property (rd && addr == 8'h08 |=> rdata[23:16] == 8'h04)
        else $error("Sub-class byte not 04h");
    chk_baseclass_byte: assert property (rd && addr == 8'h08 |=> rdata[31:24] == 8'h06)
        else $error("Base class byte not 06h");
    chk_cache_line_rw: assert property (wr && addr == 8'h0C ##1 rd && addr == 8'h0C
        |=> rdata[7:0] == $past(wdata[7:0], 2))
        else $error("Cache line size did not read back");
    chk_latency_zero: assert property (rd && (addr == 8'h0C || addr == 8'h18)
        |=> (rdata[15:8] == 8'h00 || $past(addr) == 8'h18)
        && (rdata[31:24] == 8'h00 || $past(addr) == 8'h0C))
        else $error("Latency timer not zero");
    chk_header_type: assert property (rd && addr == 8'h0C |=> rdata[23:16] == 8'h01)
        else $error("Header type not 01h");
    // Bus number word.
    chk_upstream_bus: assert property (wr && addr == 8'h18
        |=> upstream_bus_number == $past(wdata[7:0]))
        else $error("Upstream bus number not written");
    chk_downstream_bus: assert property (wr && addr == 8'h18
        |=> downstream_bus_number == $past(wdata[15:8]))
        else $error("Downstream bus number not written");
    chk_highest_bus: assert property (wr && addr == 8'h18
        |=> highest_bus_number == $past(wdata[23:16]))
        else $error("Highest bus number not written");
    chk_bus_hold: assert property (!(wr && addr == 8'h18)
        |=> $stable(upstream_bus_number) && $stable(downstream_bus_number)
        && $stable(highest_bus_number))
        else $error("Bus numbers changed without a write");
    // I/O window word.
    chk_io_capability: assert property (rd && addr == 8'h1C
        |=> rdata[3:0] == 4'h1 && rdata[11:8] == 4'h1)
        else $error("I/O capability nibble not 1");
    chk_io_nibbles: assert property (wr && addr == 8'h1C ##1 rd && addr == 8'h1C
        |=> rdata[7:4] == $past(wdata[7:4], 2) && rdata[15:12] == $past(wdata[15:12], 2))
        else $error("I/O window nibbles did not read back");
    chk_ro_write_ignored: assert property (wr && addr == 8'h08 ##1 rd && addr == 8'h08
        |=> rdata == {8'h06, 8'h04, 8'h00, REVISION_CODE})
        else $error("Write changed a read-only field");
    chk_idle_read_zero: assert property (!rd |=> rdata == 32'h0000_0000)
        else $error("Read data not zero outside a read");

    // Each writable field moves only on a write to its own word.
    chk_cache_line_write: assert property (wr && addr == 8'h0C
        |=> cache_line_size_reg == $past(wdata[7:0]))
        else $error("Cache line size not written");
    chk_cache_line_hold: assert property (!(wr && addr == 8'h0C)
        |=> $stable(cache_line_size_reg))
        else $error("Cache line size changed without a write");
    chk_io_nib_write: assert property (wr && addr == 8'h1C
        |=> io_base_nib_reg == $past(wdata[7:4]) && io_limit_nib_reg == $past(wdata[15:12]))
        else $error("I/O window nibbles not written");
    chk_io_nib_hold: assert property (!(wr && addr == 8'h1C)
        |=> $stable(io_base_nib_reg) && $stable(io_limit_nib_reg))
        else $error("I/O window nibbles changed without a write");

    // A read returns the contents held in the cycle in which it is taken.
    chk_header_readback: assert property (rd && addr == 8'h0C
        |=> rdata[7:0] == $past(cache_line_size_reg))
        else $error("Cache line size read back wrong");
    chk_bus_readback: assert property (rd && addr == 8'h18
        |=> rdata[23:0] == {$past(highest_bus_reg), $past(downstream_bus_reg),
        $past(upstream_bus_reg)})
        else $error("Bus number word read back wrong");
    chk_io_readback: assert property (rd && addr == 8'h1C
        |=> rdata[7:4] == $past(io_base_nib_reg) && rdata[15:12] == $past(io_limit_nib_reg))
        else $error("I/O window nibbles read back wrong");
    chk_bus_write_read: assert property (wr && addr == 8'h18 ##1 rd && addr == 8'h18
        |=> rdata == {8'h00, $past(wdata[23:0], 2)})
        else $error("Bus number word did not read back");
    chk_io_upper_zero: assert property (rd && (addr == 8'h0C || addr == 8'h1C)
        |=> rdata[31:24] == 8'h00 && ($past(addr) == 8'h0C || rdata[23:16] == 8'h00))
        else $error("Bits owned by other registers not zero");
    chk_unmapped_zero: assert property (rd && addr != 8'h08 && addr != 8'h0C
        && addr != 8'h18 && addr != 8'h1C |=> rdata == 32'h0000_0000)
        else $error("Unmapped read returned data");
    chk_ro_write_header: assert property (wr && addr == 8'h0C ##1 rd && addr == 8'h0C
        |=> rdata[31:8] == 24'h00_0100)
        else $error("Write changed a hardwired header byte");
    chk_ro_write_io: assert property (wr && addr == 8'h1C ##1 rd && addr == 8'h1C
        |=> rdata[3:0] == 4'h1 && rdata[11:8] == 4'h1 && rdata[31:16] == 16'h0000)
        else $error("Write changed a hardwired I/O byte");

    // Leaving reset, every field shows its reset value before the first access lands.
    chk_reset_bus: assert property ($rose(rst_n)
        |-> upstream_bus_number == 8'h00 && downstream_bus_number == 8'h00
        && highest_bus_number == 8'h00)
        else $error("Bus numbers not cleared by reset");
    chk_reset_cache: assert property ($rose(rst_n) |-> cache_line_size_reg == 8'h00)
        else $error("Cache line size not cleared by reset");
    chk_reset_nibbles: assert property ($rose(rst_n)
        |-> io_base_nib_reg == 4'h0 && io_limit_nib_reg == 4'h0)
        else $error("I/O window nibbles not cleared by reset");
    chk_reset_rdata: assert property ($rose(rst_n) |-> rdata == 32'h0000_0000)
        else $error("Read data not cleared by reset");

    // Forwarding decisions against the nibbles held in this block.
    chk_decided_follows: assert property (io_valid |=> io_decided)
        else $error("I/O request got no decision");
    chk_forward_decided: assert property (io_forward |-> io_decided)
        else $error("Forward raised without a decision");
    chk_bottom_edge_hit: assert property (io_valid
        && io_addr == {io_base_upper, io_base_nib_reg, 12'h000}
        && {io_base_upper, io_base_nib_reg} <= {io_limit_upper, io_limit_nib_reg} |=> io_forward)
        else $error("Window bottom address not forwarded");
    chk_top_edge_hit: assert property (io_valid
        && io_addr == {io_limit_upper, io_limit_nib_reg, 12'hFFF}
        && {io_base_upper, io_base_nib_reg} <= {io_limit_upper, io_limit_nib_reg} |=> io_forward)
        else $error("Window top address not forwarded");

    cov_bus_program: cover property (wr && addr == 8'h18 ##1 rd && addr == 8'h18);
    cov_io_program: cover property (wr && addr == 8'h1C ##1 io_valid ##1 io_forward);
    cov_class_read: cover property (rd && addr == 8'h08);
endmodule
`default_nettype wire

// ---- design/bridge_cfg_pkg.sv ----
// Constants for the bridge configuration header block at offsets 08h to 1Ch.
package bridge_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFS_CLASS = 8'h08;
    localparam logic [7:0] OFS_HEADER = 8'h0C;
    localparam logic [7:0] OFS_BUS = 8'h18;
    localparam logic [7:0] OFS_IO = 8'h1C;

    // Field positions (least significant bit of each field).
    localparam int REV_LSB = 0;
    localparam int PROG_IF_LSB = 8;
    localparam int SUBCLASS_LSB = 16;
    localparam int BASECLASS_LSB = 24;
    localparam int CLSZ_LSB = 0;
    localparam int PRI_LAT_LSB = 8;
    localparam int HDR_TYPE_LSB = 16;
    localparam int UP_BUS_LSB = 0;
    localparam int DOWN_BUS_LSB = 8;
    localparam int HIGH_BUS_LSB = 16;
    localparam int SEC_LAT_LSB = 24;
    localparam int IO_BASE_CAP_LSB = 0;
    localparam int IO_BASE_LSB = 4;
    localparam int IO_LIMIT_CAP_LSB = 8;
    localparam int IO_LIMIT_LSB = 12;

    // Hardwired field values.
    localparam logic [7:0] PROG_IF_VAL = 8'h00;
    localparam logic [7:0] SUBCLASS_VAL = 8'h04;
    localparam logic [7:0] BASECLASS_VAL = 8'h06;
    localparam logic [7:0] LATENCY_VAL = 8'h00;
    localparam logic [7:0] HDR_TYPE_VAL = 8'h01;
    localparam logic [3:0] IO_CAP_VAL = 4'h1;

    // Reset values of the writable fields.
    localparam logic [7:0] CLSZ_RST = 8'h00;
    localparam logic [7:0] BUS_RST = 8'h00;
    localparam logic [3:0] IO_NIB_RST = 4'h0;

    // Low twelve address bits of the window edges.
    localparam logic [11:0] IO_LOW_ZERO = 12'h000;
    localparam logic [11:0] IO_LOW_ONES = 12'hFFF;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // True when addr lies in the inclusive range from bottom to top.
    function automatic logic in_window(input logic [31:0] addr, input logic [31:0] bottom,
                                       input logic [31:0] top);
        in_window = (addr >= bottom) && (addr <= top);
    endfunction
endpackage

// ---- design/io_window_check.sv ----
// Registered I/O forwarding decision against the programmed I/O window.
`timescale 1ns/1ps
`default_nettype none
module io_window_check
    import bridge_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] base_nib,
    input wire logic [3:0] limit_nib,
    input wire logic [15:0] base_upper,
    input wire logic [15:0] limit_upper,
    input wire logic io_valid,
    input wire logic [31:0] io_addr,
    output logic io_decided,
    output logic io_forward
);
    logic [31:0] window_bottom;
    logic [31:0] window_top;
    logic decided_reg;
    logic forward_reg;

    // Upper halves come from the separate upper registers.
    assign window_bottom = {base_upper, base_nib, IO_LOW_ZERO};
    assign window_top = {limit_upper, limit_nib, IO_LOW_ONES};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            decided_reg <= 1'b0;
            forward_reg <= 1'b0;
        end
        else
        begin
            decided_reg <= io_valid;
            forward_reg <= io_valid && in_window(io_addr, window_bottom, window_top);
        end
    end

    assign io_decided = decided_reg;
    assign io_forward = forward_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_window_range: assert property (io_valid |=> io_forward ==
        (($past(io_addr) >= {$past(base_upper), $past(base_nib), 12'h000})
        && ($past(io_addr) <= {$past(limit_upper), $past(limit_nib), 12'hFFF})))
        else $error("I/O forward decision disagrees with window");
    chk_upper_half: assert property (io_valid && io_addr[31:16] > limit_upper |=> !io_forward)
        else $error("Address above upper limit half was forwarded");
    chk_base_floor: assert property (io_valid && io_addr[31:16] == base_upper
        && io_addr[15:12] < base_nib |=> !io_forward)
        else $error("Address below window bottom was forwarded");
    chk_limit_ceiling: assert property (io_valid && base_upper == limit_upper
        && io_addr[31:16] == limit_upper && io_addr[15:12] == limit_nib
        && base_nib <= limit_nib |=> io_forward)
        else $error("Address in top 4 KB of window not forwarded");
    chk_idle_quiet: assert property (!io_valid |=> !io_forward && !io_decided)
        else $error("Forward decision raised without a request");

    cov_forward_hit: cover property (io_valid ##1 io_forward);
    cov_forward_miss: cover property (io_valid ##1 !io_forward);
endmodule
`default_nettype wire

// ---- tb/bridge_config_header_08_1c_tb.sv ----
// Self-checking testbench for the bridge configuration header block.
`timescale 1ns/1ps
`default_nettype none
module bridge_config_header_08_1c_tb;
    import bridge_cfg_pkg::*;
    // Arbitrary revision value chosen for this bench.
    localparam logic [7:0] REV_VAL = 8'h3C;
    localparam logic [31:0] CLASS_WORD = {8'h06, 8'h04, 8'h00, REV_VAL};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [7:0] upstream_bus_number;
    logic [7:0] downstream_bus_number;
    logic [7:0] highest_bus_number;
    logic [15:0] io_base_upper = 16'h0000;
    logic [15:0] io_limit_upper = 16'h0000;
    logic io_valid = 1'b0;
    logic [31:0] io_addr = 32'h0000_0000;
    logic io_decided;
    logic io_forward;
    logic [31:0] io_a [6];
    logic io_e [6];
    int n_mismatch = 0;
    int checks = 0;

    always #20 clk = ~clk;

    bridge_config_header_08_1c #(.REVISION_CODE(REV_VAL)) DUT (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .upstream_bus_number(upstream_bus_number),
        .downstream_bus_number(downstream_bus_number),
        .highest_bus_number(highest_bus_number), .io_base_upper(io_base_upper),
        .io_limit_upper(io_limit_upper), .io_valid(io_valid), .io_addr(io_addr),
        .io_decided(io_decided), .io_forward(io_forward)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic read_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask

    // Write then read the same word in the next cycle, with no gap between the strobes.
    task automatic wr_rd_chk(input string name, input logic [7:0] a, input logic [31:0] d,
                             input logic [31:0] exp);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask

    task automatic check_bus(input logic [23:0] exp);
        check("bus numbers", {8'h00, highest_bus_number, downstream_bus_number,
            upstream_bus_number}, {8'h00, exp});
    endtask

    // Sends io_a back to back with io_valid held high and checks each answer a cycle later.
    task automatic io_burst(input int n);
        for (int i = 0; i <= n; i++)
        begin
            @(posedge clk);
            io_valid <= (i < n);
            if (i < n)
                io_addr <= io_a[i];
            #1;
            if (i > 0)
            begin
                check("io_decided", 32'(io_decided), 32'h0000_0001);
                check("io_forward", 32'(io_forward), 32'(io_e[i-1]));
            end
        end
        @(posedge clk);
        #1;
        check("io_decided idle", 32'(io_decided), 32'h0000_0000);
    endtask

    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check_bus(24'h00_0000);
        read_chk("class word", OFS_CLASS, CLASS_WORD);
        read_chk("header word", OFS_HEADER, 32'h0001_0000);
        read_chk("bus word", OFS_BUS, 32'h0000_0000);
        read_chk("io word", OFS_IO, 32'h0000_0101);
        io_a = '{32'h0000_0000, 32'h0000_0FFF, 32'h0000_1000, 32'h0001_0000, 32'h0000_0000,
                 32'h0000_0000};
        io_e = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        io_burst(4);
        $display("test reset values done");

        @(posedge clk);
        wr <= 1'b1;
        addr <= OFS_BUS;
        wdata <= 32'hFF05_0201;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        #1;
        check_bus(24'h05_0201);
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("bus word b2b", rdata, 32'h0005_0201);
        @(posedge clk);
        #1;
        check("rdata idle", rdata, 32'h0000_0000);
        write(OFS_IO, 32'hFFFF_3020);
        read_chk("io word", OFS_IO, 32'h0000_3121);
        @(posedge clk);
        io_base_upper <= 16'h0001;
        io_limit_upper <= 16'h0002;
        io_a = '{32'h0001_1FFF, 32'h0001_2000, 32'h0002_3FFF, 32'h0002_4000,
                 32'h0000_2000, 32'h0001_FFFF};
        io_e = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        io_burst(6);
        $display("test window decode done");

        wr_rd_chk("class b2b", OFS_CLASS, 32'hFFFF_FFFF, CLASS_WORD);
        wr_rd_chk("header b2b", OFS_HEADER, 32'hFFFF_FFFF, 32'h0001_00FF);
        write(OFS_BUS, 32'hFFFF_FFFF);
        read_chk("class word", OFS_CLASS, CLASS_WORD);
        read_chk("header word", OFS_HEADER, 32'h0001_00FF);
        read_chk("bus word", OFS_BUS, 32'h00FF_FFFF);
        check_bus(24'hFF_FFFF);
        io_burst(6);
        write(8'h10, 32'hFFFF_FFFF);
        check_bus(24'hFF_FFFF);
        read_chk("unmapped", 8'h10, 32'h0000_0000);
        read_chk("misaligned", 8'h19, 32'h0000_0000);
        wr_rd_chk("io word", OFS_IO, 32'hFFFF_FFFF, 32'h0000_F1F1);
        $display("test write masks done");

        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        check_bus(24'h00_0000);
        @(posedge clk);
        rst_n <= 1'b1;
        read_chk("header word", OFS_HEADER, 32'h0001_0000);
        read_chk("io word", OFS_IO, 32'h0000_0101);
        $display("test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
